/* verilog/telecom_bus_alarm_status.sv */
// Alarm and status monitor for the A/B drop and B add telecom buses.
// Assumes bus signals are synchronous to their own bus clocks and
// that those clocks are well below a quarter of the 125 MHz CLK_I.
//
// Operation
// - External desync clock stuck about 1000 ns raises its loss flag.
// - Each clock loss flag clears on the first clock transition.
// - H4 multiframe loss after mismatches in two consecutive multiframes, format bit 0.
// - Expected H4 phase steps 00, 01, 10, 11, one per frame.
// - Reference counter keeps free running during multiframe loss.
// - Checker realigns after one full correct multiframe sequence, except one already four steps long when loss is declared.
// - Slot 2 and 3 H4 detectors off in single payload formats.
// - H4 loss bits come up as 1 after reset.
// - B drop clock stuck about 1000 ns raises drop clock loss.
// - Drop timing with drop clock loss floats add data, drops indicator.
// - Add timing with add clock loss flags, floats add data, drops indicator.
// - Drop parity checked each drop clock; mismatch only sets alarm.
// - Unused status bits read as zero.
// - Upstream AIS from H1/H2 or from E1x byte per select bit.
// - Slot 2 and 3 AIS indications off in single payload formats.
// - Each live status register has a latched twin, same layout.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module telecom_bus_alarm_status (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    output logic IRQ_O,
    // External desynchronizer clock
    input wire logic DESYNC_REF_CLOCK_IN_I,
    // A drop bus
    input wire logic A_DROP_CLK_I,
    input wire logic [2:0] A_DROP_H4_I,
    input wire logic [1:0] A_DROP_H4_DATA_I,
    // B drop bus
    input wire logic B_DROP_CLK_I,
    input wire logic [7:0] B_DROP_DATA_I,
    input wire logic B_DROP_PAR_I,
    input wire logic [2:0] B_DROP_H4_I,
    input wire logic [2:0] B_DROP_H1_I,
    input wire logic [2:0] B_DROP_H2_I,
    input wire logic [2:0] B_DROP_E1_I,
    // B add bus
    input wire logic B_ADD_CLK_I,
    input wire logic [7:0] ADD_DATA_I,
    input wire logic ADD_PAR_I,
    input wire logic ADD_IND_I,
    output logic [7:0] B_ADD_DATA_O,
    output logic B_ADD_PAR_O,
    output logic B_ADD_OE_O,
    output logic B_ADD_IND_O
);
    // Latched bit: live rise sets, written one clears, set wins
    function automatic logic [7:0] w1c(input logic [7:0] lat, input logic [7:0] live,
                                       input logic [7:0] prev, input logic hit,
                                       input logic [7:0] wd);
        logic [7:0] clr;
        clr = hit ? wd : 8'h00;
        return (lat & ~clr) | (live & ~prev);
    endfunction

    logic [7:0] cfg_r;
    logic [7:0] msk_a_r;
    logic [7:0] msk_b_r;
    logic [7:0] msk_h_r;
    logic [7:0] lat_a_r;
    logic [7:0] lat_b_r;
    logic [7:0] lat_h_r;
    logic [7:0] prev_a_r;
    logic [7:0] prev_b_r;
    logic [7:0] prev_h_r;
    logic [7:0] rdata_r;
    logic [alarm_pkg::BS_W-1:0] b_s1_r;
    logic [alarm_pkg::BS_W-1:0] b_s2_r;
    logic [alarm_pkg::AS_W-1:0] a_s1_r;
    logic [alarm_pkg::AS_W-1:0] a_s2_r;
    logic par_err_r;
    logic [2:0] h1ff_r;
    logic [2:0] ais_ptr_r;
    logic [2:0] ais_e_r;
    logic [7:0] add_data_r;
    logic add_par_r;
    logic add_ind_r;
    logic seen_h4_r;

    logic ext_loss;
    logic a_rise;
    logic b_rise;
    logic drop_loss;
    logic add_loss_raw;
    logic [5:0] h4_loss_w;

    // Clock loss monitors
    clock_stall_detect u_ext (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .mon_clk_i(DESYNC_REF_CLOCK_IN_I),
        .rise_o(),
        .loss_o(ext_loss)
    );
    clock_stall_detect u_adrop (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .mon_clk_i(A_DROP_CLK_I),
        .rise_o(a_rise),
        .loss_o()
    );
    clock_stall_detect u_bdrop (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .mon_clk_i(B_DROP_CLK_I),
        .rise_o(b_rise),
        .loss_o(drop_loss)
    );
    clock_stall_detect u_badd (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .mon_clk_i(B_ADD_CLK_I),
        .rise_o(),
        .loss_o(add_loss_raw)
    );

    // Configuration decode
    wire fmt_sel = cfg_r[alarm_pkg::CFG_FMT_SEL];
    wire single = cfg_r[alarm_pkg::CFG_SINGLE];
    wire odd_par = cfg_r[alarm_pkg::CFG_ODD];
    wire ais_sel = cfg_r[alarm_pkg::CFG_AIS_SEL];
    wire add_tim = cfg_r[alarm_pkg::CFG_ADD_TIM];
    wire [2:0] slot_mask = single ? alarm_pkg::SLOT_FIRST : alarm_pkg::SLOT_ALL;

    // Synchronised drop bus fields
    wire [7:0] b_data = b_s2_r[alarm_pkg::BS_DATA +: 8];
    wire b_par = b_s2_r[alarm_pkg::BS_PAR];
    wire [2:0] b_h1 = b_s2_r[alarm_pkg::BS_H1 +: 3] & {3{b_rise}};
    wire [2:0] b_h2 = b_s2_r[alarm_pkg::BS_H2 +: 3] & {3{b_rise}};
    wire [2:0] b_e1 = b_s2_r[alarm_pkg::BS_E1 +: 3] & {3{b_rise}};
    wire [2:0] b_h4 = b_s2_r[alarm_pkg::BS_H4 +: 3] & {3{b_rise}};
    wire [2:0] a_h4 = a_s2_r[alarm_pkg::AS_H4 +: 3] & {3{a_rise}};
    wire [1:0] a_val = a_s2_r[alarm_pkg::AS_VAL +: 2];
    wire [5:0] h4_stb = {b_h4, a_h4};
    wire [2:0] byte_ais = {3{b_data == alarm_pkg::AIS_BYTE}};

    // Parity over data and parity bit, even or odd
    wire par_bad = (^{b_par, b_data}) != odd_par;
    wire par_nxt = b_rise ? par_bad : par_err_r;

    // Upstream AIS per slot
    wire [2:0] h1ff_nxt = (h1ff_r & ~b_h1) | (b_h1 & byte_ais);
    wire [2:0] ptr_nxt = (ais_ptr_r & ~b_h2) | (b_h2 & byte_ais & h1ff_r);
    wire [2:0] e_nxt = (ais_e_r & ~b_e1) | (b_e1 & byte_ais);
    wire [2:0] ais_live = (ais_sel ? ais_e_r : ais_ptr_r) & slot_mask;

    // Add bus inhibit by timing source
    wire add_loss = add_tim && add_loss_raw;
    wire inhibit = add_tim ? add_loss_raw : drop_loss;

    // H4 multiframe checkers, A slots 0-2 then B slots 3-5
    wire [5:0] h4_en = {6{!fmt_sel}} & {slot_mask, slot_mask};
    wire [5:0] h4_live = h4_loss_w & h4_en;

    genvar s;
    generate
        for (s = 0; s < 2 * alarm_pkg::NSLOT; s++)
        begin : g_h4
            logic [1:0] ref_r;
            logic [1:0] prev_r;
            logic [1:0] bad_r;
            logic [2:0] run_r;
            logic err_r;
            logic loss_r;
            wire stb = h4_stb[s];
            wire [1:0] val = (s < alarm_pkg::NSLOT) ? a_val : b_data[1:0];
            wire [1:0] expect_v = ref_r + 2'h1;
            wire miss = (val != expect_v) || err_r;
            wire last = (expect_v == alarm_pkg::H4_LAST);
            wire seq_ok = (val == prev_r + 2'h1);
            wire relock = loss_r && stb && seq_ok && (run_r == alarm_pkg::H4_LOCK_RUN - 3'h1);
            wire mf_end = stb && last;
            wire declare = mf_end && miss && (bad_r == alarm_pkg::H4_LOSS_MF - 2'h1);
            wire [1:0] ref_nxt = stb ? (relock ? val : expect_v) : ref_r;
            wire err_nxt = stb ? (!last && miss && !relock) : err_r;
            wire [1:0] bad_nxt = (relock || (mf_end && !miss)) ? 2'h0 :
                                 (mf_end && bad_r != alarm_pkg::H4_LOSS_MF) ? bad_r + 2'h1 : bad_r;
            wire loss_nxt = relock ? 1'b0 : (declare ? 1'b1 : loss_r);
            wire [2:0] run_nxt = (!stb || relock) ? (relock ? 3'h0 : run_r) :
                                 (!seq_ok ? 3'h0 :
                                 (run_r == alarm_pkg::H4_LOCK_RUN ? run_r : run_r + 3'h1));

            assign h4_loss_w[s] = loss_r;

            always_ff @(posedge CLK_I or negedge RSTN_I)
            begin
                if (!RSTN_I)
                begin
                    ref_r <= 2'h0;
                    prev_r <= 2'h0;
                    bad_r <= 2'h0;
                    run_r <= 3'h0;
                    err_r <= 1'b0;
                    loss_r <= 1'b1;
                end
                else
                begin
                    ref_r <= ref_nxt;
                    prev_r <= stb ? val : prev_r;
                    bad_r <= bad_nxt;
                    run_r <= run_nxt;
                    err_r <= err_nxt;
                    loss_r <= loss_nxt;
                end
            end

            h4_freerun_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
                stb && loss_r && !relock |=> ref_r == $past(expect_v))
                else $error("reference counter did not advance");
            h4_declare_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
                $rose(loss_r) |-> $past(mf_end) && $past(bad_r) == alarm_pkg::H4_LOSS_MF - 2'h1)
                else $error("multiframe loss raised without two bad multiframes");
        end
    endgenerate

    // Live and latched status words
    wire [7:0] live_a = {ext_loss, 4'h0, h4_live[2:0]};
    wire [7:0] live_b = {drop_loss, add_loss, par_err_r, 2'h0, ais_live};
    wire [7:0] live_h = {5'h00, h4_live[5:3]};

    wire wr_lat_a = WR_I && (ADDR_I == alarm_pkg::OFS_A_LAT);
    wire wr_lat_b = WR_I && (ADDR_I == alarm_pkg::OFS_B_LAT);
    wire wr_lat_h = WR_I && (ADDR_I == alarm_pkg::OFS_H4_LAT);
    wire [7:0] lat_a_nxt = w1c(lat_a_r, live_a, prev_a_r, wr_lat_a, WDATA_I);
    wire [7:0] lat_b_nxt = w1c(lat_b_r, live_b, prev_b_r, wr_lat_b, WDATA_I);
    wire [7:0] lat_h_nxt = w1c(lat_h_r, live_h, prev_h_r, wr_lat_h, WDATA_I);

    // Read selection, unmapped reads return zero
    wire [7:0] rd_mux =
        (ADDR_I == alarm_pkg::OFS_A_LAT) ? lat_a_r :
        (ADDR_I == alarm_pkg::OFS_A_LIVE) ? live_a :
        (ADDR_I == alarm_pkg::OFS_B_LAT) ? lat_b_r :
        (ADDR_I == alarm_pkg::OFS_B_LIVE) ? live_b :
        (ADDR_I == alarm_pkg::OFS_H4_LAT) ? lat_h_r :
        (ADDR_I == alarm_pkg::OFS_H4_LIVE) ? live_h :
        (ADDR_I == alarm_pkg::OFS_CFG) ? cfg_r :
        (ADDR_I == alarm_pkg::OFS_MSK_A) ? msk_a_r :
        (ADDR_I == alarm_pkg::OFS_MSK_B) ? msk_b_r :
        (ADDR_I == alarm_pkg::OFS_MSK_H4) ? msk_h_r : 8'h00;

    assign RDATA_O = rdata_r;
    assign IRQ_O = |{lat_a_r & msk_a_r, lat_b_r & msk_b_r, lat_h_r & msk_h_r};
    assign B_ADD_DATA_O = add_data_r;
    assign B_ADD_PAR_O = add_par_r;
    assign B_ADD_OE_O = !inhibit;
    assign B_ADD_IND_O = add_ind_r && !inhibit;

    // Synchronisers for bus fields
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            b_s1_r <= '0;
            b_s2_r <= '0;
            a_s1_r <= '0;
            a_s2_r <= '0;
        end
        else
        begin
            b_s1_r <= {B_DROP_PAR_I, B_DROP_DATA_I, B_DROP_H4_I, B_DROP_H1_I, B_DROP_H2_I,
                       B_DROP_E1_I};
            b_s2_r <= b_s1_r;
            a_s1_r <= {A_DROP_H4_I, A_DROP_H4_DATA_I};
            a_s2_r <= a_s1_r;
        end
    end

    // Drop bus alarms and add bus data
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            par_err_r <= 1'b0;
            h1ff_r <= 3'h0;
            ais_ptr_r <= 3'h0;
            ais_e_r <= 3'h0;
            add_data_r <= 8'h00;
            add_par_r <= 1'b0;
            add_ind_r <= 1'b0;
            seen_h4_r <= 1'b0;
        end
        else
        begin
            par_err_r <= par_nxt;
            h1ff_r <= h1ff_nxt;
            ais_ptr_r <= ptr_nxt;
            ais_e_r <= e_nxt;
            add_data_r <= ADD_DATA_I;
            add_par_r <= ADD_PAR_I;
            add_ind_r <= ADD_IND_I;
            seen_h4_r <= seen_h4_r || (|h4_stb);
        end
    end

    // Register file
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            cfg_r <= alarm_pkg::CFG_RESET;
            msk_a_r <= alarm_pkg::MSK_RESET;
            msk_b_r <= alarm_pkg::MSK_RESET;
            msk_h_r <= alarm_pkg::MSK_RESET;
            rdata_r <= 8'h00;
        end
        else
        begin
            if (WR_I && ADDR_I == alarm_pkg::OFS_CFG)
                cfg_r <= WDATA_I & alarm_pkg::CFG_USED;
            if (WR_I && ADDR_I == alarm_pkg::OFS_MSK_A)
                msk_a_r <= WDATA_I;
            if (WR_I && ADDR_I == alarm_pkg::OFS_MSK_B)
                msk_b_r <= WDATA_I;
            if (WR_I && ADDR_I == alarm_pkg::OFS_MSK_H4)
                msk_h_r <= WDATA_I;
            rdata_r <= RD_I ? rd_mux : 8'h00;
        end
    end

    // Latched twins and live history
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            lat_a_r <= 8'h00;
            lat_b_r <= 8'h00;
            lat_h_r <= 8'h00;
            prev_a_r <= 8'h00;
            prev_b_r <= 8'h00;
            prev_h_r <= 8'h00;
        end
        else
        begin
            lat_a_r <= lat_a_nxt;
            lat_b_r <= lat_b_nxt;
            lat_h_r <= lat_h_nxt;
            prev_a_r <= live_a;
            prev_b_r <= live_b;
            prev_h_r <= live_h;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    h4_powerup_a: assert property (!seen_h4_r |-> &h4_loss_w)
        else $error("multiframe loss not set before first check");
    h4_format_a: assert property (single |-> live_a[2:1] == 2'h0 && live_h[2:1] == 2'h0)
        else $error("slot 2 or 3 multiframe loss shown in single format");
    drop_float_a: assert property (!add_tim && drop_loss |-> !B_ADD_OE_O && !B_ADD_IND_O)
        else $error("add bus driven during drop clock loss");
    add_float_a: assert property (add_tim && add_loss_raw |-> !B_ADD_OE_O && live_b[alarm_pkg::ST_ALOC])
        else $error("add clock loss not flagged or add bus driven");
    parity_flag_a: assert property (b_rise && par_bad |=> live_b[alarm_pkg::ST_PAR])
        else $error("parity mismatch not flagged");
    unused_zero_a: assert property (RD_I && ADDR_I == alarm_pkg::OFS_B_LIVE |=> RDATA_O[4:3] == 2'h0)
        else $error("unused status bits read nonzero");
    ais_source_a: assert property (ais_sel && !single && b_e1[1] && b_data == alarm_pkg::AIS_BYTE |=> live_b[1])
        else $error("E1x AIS byte not reported");
    ais_format_a: assert property (single |-> live_b[2:1] == 2'h0)
        else $error("slot 2 or 3 AIS shown in single format");
    latch_hold_a: assert property ($rose(live_b[alarm_pkg::ST_LOC]) |=> lat_b_r[alarm_pkg::ST_LOC] [*2])
        else $error("latched drop clock loss not held");

    drop_loss_cv: cover property ($rose(drop_loss));
    parity_cv: cover property ($rose(par_err_r));
    h4_relock_cv: cover property ($fell(h4_loss_w[0]));
    irq_cv: cover property ($rose(IRQ_O));
endmodule // telecom_bus_alarm_status
`default_nettype wire

/* verilog/alarm_pkg.sv */
// Constants for the telecom bus alarm and status block.
// Assumes a 125 MHz system clock and an 8-bit register port.
`default_nettype none
package alarm_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int LOC_TIME_NS = 1000;
    localparam int LOC_TOL_NS = 500;
    localparam int LOC_CYCLES = LOC_TIME_NS / CLK_PERIOD_NS;
    localparam int LOC_CNT_W = 8;
    // Register offsets
    localparam logic [7:0] OFS_A_LAT = 8'h24;
    localparam logic [7:0] OFS_A_LIVE = 8'h25;
    localparam logic [7:0] OFS_B_LAT = 8'h26;
    localparam logic [7:0] OFS_B_LIVE = 8'h27;
    localparam logic [7:0] OFS_H4_LAT = 8'h28;
    localparam logic [7:0] OFS_H4_LIVE = 8'h29;
    localparam logic [7:0] OFS_CFG = 8'h2A;
    localparam logic [7:0] OFS_MSK_A = 8'h34;
    localparam logic [7:0] OFS_MSK_B = 8'h36;
    localparam logic [7:0] OFS_MSK_H4 = 8'h38;
    // Status fields
    localparam int ST_LOC = 7;
    localparam int ST_ALOC = 6;
    localparam int ST_PAR = 5;
    localparam int ST_UNUSED_LO = 3;
    localparam int ST_SLOT = 0;
    // Configuration fields
    localparam int CFG_FMT_SEL = 0;
    localparam int CFG_SINGLE = 1;
    localparam int CFG_ODD = 2;
    localparam int CFG_AIS_SEL = 3;
    localparam int CFG_ADD_TIM = 4;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_USED = 8'h1F;
    localparam logic [7:0] MSK_RESET = 8'h00;
    // Slots and H4 checking
    localparam int NSLOT = 3;
    localparam logic [2:0] SLOT_ALL = 3'h7;
    localparam logic [2:0] SLOT_FIRST = 3'h1;
    localparam logic [1:0] H4_LAST = 2'h3;
    localparam logic [1:0] H4_LOSS_MF = 2'h2;
    localparam logic [2:0] H4_LOCK_RUN = 3'h4;
    localparam logic [7:0] AIS_BYTE = 8'hFF;
    // Synchroniser layouts
    localparam int BS_E1 = 0;
    localparam int BS_H2 = 3;
    localparam int BS_H1 = 6;
    localparam int BS_H4 = 9;
    localparam int BS_DATA = 12;
    localparam int BS_PAR = 20;
    localparam int BS_W = 21;
    localparam int AS_VAL = 0;
    localparam int AS_H4 = 2;
    localparam int AS_W = 5;
endpackage
`default_nettype wire

/* verilog/clock_stall_detect.sv */
// Clock stall detector: synchronises a foreign clock, finds its edges.
// Assumes the monitored clock is far slower than clk_i.
`timescale 1ns/1ps
`default_nettype none
module clock_stall_detect (
    // System side
    input wire logic clk_i,
    input wire logic rstn_i,
    // Monitored clock
    input wire logic mon_clk_i,
    // Results
    output logic rise_o,
    output logic loss_o
);
    localparam logic [alarm_pkg::LOC_CNT_W-1:0] LIM =
        alarm_pkg::LOC_CNT_W'(alarm_pkg::LOC_CYCLES - 1);

    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic loss_r;
    logic [alarm_pkg::LOC_CNT_W-1:0] cnt_r;
    logic [alarm_pkg::LOC_CNT_W-1:0] cnt_nxt;
    logic loss_nxt;
    wire edge_w = sync2_r ^ prev_r;
    wire at_lim_w = (cnt_r == LIM);

    // Count system cycles since the last edge of either sense
    assign cnt_nxt = edge_w ? '0 : (at_lim_w ? cnt_r : cnt_r + 1'b1);
    assign loss_nxt = !edge_w && (loss_r || at_lim_w);
    assign rise_o = sync2_r && !prev_r;
    assign loss_o = loss_r;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= mon_clk_i;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_r <= '0;
            loss_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            loss_r <= loss_nxt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    loss_after_stall_a: assert property ($rose(loss_r) |-> $past(cnt_r) == LIM)
        else $error("stall alarm raised at wrong count");
    loss_recover_a: assert property (edge_w |=> !loss_r)
        else $error("stall alarm not cleared by clock edge");
    loss_cv: cover property ($rose(loss_r));
endmodule // clock_stall_detect
`default_nettype wire

/* bench/drop_bus_model.sv */
// Upstream framer model: B drop bus fields and the B add clock.
// Assumes the bench sets the fields at most once per drop clock period.
`timescale 1ns/1ps
`default_nettype none
module drop_bus_model (
    // Control from the bench
    input wire logic drop_run_i,
    input wire logic add_run_i,
    input wire logic [7:0] byte_i,
    input wire logic par_i,
    input wire logic [2:0] h1_i,
    input wire logic [2:0] h2_i,
    input wire logic [2:0] e1_i,
    input wire logic [2:0] h4_i,
    // Bus toward the block
    output logic drop_clk_o,
    output logic add_clk_o,
    output logic [7:0] data_o,
    output logic par_o,
    output logic [2:0] h1_o,
    output logic [2:0] h2_o,
    output logic [2:0] e1_o,
    output logic [2:0] h4_o
);
    // Half period 80 ns, edges 4 ns after time zero, landing on system clock rising edges
    initial
    begin
        {drop_clk_o, add_clk_o, data_o, par_o, h1_o, h2_o, e1_o, h4_o} = '0;
        #4;
        forever
        begin
            #80;
            if (add_run_i)
                add_clk_o = ~add_clk_o;
            if (drop_run_i)
            begin
                drop_clk_o = ~drop_clk_o;
                // Fields launched on falling edge, stable at rising
                if (!drop_clk_o)
                    {data_o, par_o, h1_o, h2_o, e1_o, h4_o} =
                        {byte_i, par_i, h1_i, h2_i, e1_i, h4_i};
            end
            else
                // Stalled clock: data lines carry no held value
                {data_o, par_o} = ~{data_o, par_o};
        end
    end
endmodule // drop_bus_model
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the telecom bus alarm and status block.
// Assumes the drop bus model above and a 125 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, ext = 0, ext_run = 0;
    logic drop_run = 1, add_run = 1, par_v = 0, add_p = 0, add_ind = 1;
    logic [7:0] addr = 0, wdata = 0, byte_v = 0, add_d = 8'hA5, v;
    logic [2:0] h1 = 0, h2 = 0, e1 = 0, h4 = 0;
    wire logic dclk, aclk, dpar, b_par, b_oe, b_ind, irq;
    wire logic [7:0] ddata, rdata, b_data;
    wire logic [2:0] dh1, dh2, de1, dh4;
    int bad_count = 0, compares = 0;
    always #4 clk = ~clk;
    initial
    begin
        #1;
        forever #80 if (ext_run) ext = ~ext;
    end
    drop_bus_model far (.drop_run_i(drop_run), .add_run_i(add_run), .byte_i(byte_v),
        .par_i(par_v), .h1_i(h1), .h2_i(h2), .e1_i(e1), .h4_i(h4), .drop_clk_o(dclk),
        .add_clk_o(aclk), .data_o(ddata), .par_o(dpar), .h1_o(dh1), .h2_o(dh2),
        .e1_o(de1), .h4_o(dh4));
    telecom_bus_alarm_status uut (.CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq),
        .DESYNC_REF_CLOCK_IN_I(ext), .A_DROP_CLK_I(1'b0), .A_DROP_H4_I(3'h0),
        .A_DROP_H4_DATA_I(2'h0), .B_DROP_CLK_I(dclk), .B_DROP_DATA_I(ddata),
        .B_DROP_PAR_I(dpar), .B_DROP_H4_I(dh4), .B_DROP_H1_I(dh1), .B_DROP_H2_I(dh2),
        .B_DROP_E1_I(de1), .B_ADD_CLK_I(aclk), .ADD_DATA_I(add_d), .ADD_PAR_I(add_p),
        .ADD_IND_I(add_ind), .B_ADD_DATA_O(b_data), .B_ADD_PAR_O(b_par),
        .B_ADD_OE_O(b_oe), .B_ADD_IND_O(b_ind));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 v = rdata & m;
        `CHK(v, e)
    endtask
    // One drop bus byte, loaded by the model at its next falling edge
    task automatic send(input logic [7:0] d, input logic [11:0] mk, input logic bad);
        @(negedge dclk);
        @(posedge clk);
        byte_v <= d;
        par_v <= ^d ^ bad;
        {h1, h2, e1, h4} <= mk;
    endtask
    task automatic flush();
        send(8'h00, 12'h000, 0);
        cyc(60);
    endtask
    task automatic t_reset();
        rd_reg(8'h25, 8'hFF, 8'h07);
        rd_reg(8'h29, 8'hFF, 8'h07);
        rd_reg(8'h27, 8'hFF, 8'h00);
        rd_reg(8'h00, 8'hFF, 8'h00);
        `CHK({b_oe, b_ind, b_data}, {2'h3, 8'hA5})
    endtask
    task automatic t_h4();
        for (int i = 0; i < 8; i++)
            send(8'(i % 4), 12'h007, 0);
        flush();
        rd_reg(8'h29, 8'hFF, 8'h00);
        for (int i = 0; i < 8; i++)
            send(8'h00, 12'h007, 0);
        flush();
        rd_reg(8'h29, 8'hFF, 8'h07);
        wr_reg(8'h2A, 8'h02);
        rd_reg(8'h29, 8'hFF, 8'h01);
        wr_reg(8'h2A, 8'h00);
    endtask
    task automatic t_par();
        send(8'h01, 12'h000, 1);
        cyc(40);
        rd_reg(8'h27, 8'h20, 8'h20);
        `CHK(b_oe, 1'b1)
        flush();
        rd_reg(8'h27, 8'h20, 8'h00);
        wr_reg(8'h2A, 8'h04);
        cyc(40);
        rd_reg(8'h27, 8'h20, 8'h20);
        wr_reg(8'h2A, 8'h00);
        cyc(40);
    endtask
    task automatic t_ais();
        send(8'hFF, 12'hE00, 0);
        send(8'hFF, 12'h1C0, 0);
        flush();
        rd_reg(8'h27, 8'h07, 8'h07);
        wr_reg(8'h2A, 8'h02);
        rd_reg(8'h27, 8'h07, 8'h01);
        wr_reg(8'h2A, 8'h08);
        send(8'hFF, 12'h010, 0);
        flush();
        rd_reg(8'h27, 8'h02, 8'h02);
        send(8'h00, 12'h010, 0);
        flush();
        rd_reg(8'h27, 8'h02, 8'h00);
        wr_reg(8'h2A, 8'h00);
    endtask
    task automatic t_loss();
        wr_reg(8'h36, 8'h80);
        wr_reg(8'h26, 8'hFF);
        `CHK(irq, 1'b0)
        drop_run <= 0;
        cyc(50);
        rd_reg(8'h27, 8'h80, 8'h00);
        cyc(140);
        rd_reg(8'h27, 8'h80, 8'h80);
        `CHK({b_oe, b_ind, irq}, 3'h1)
        drop_run <= 1;
        cyc(30);
        rd_reg(8'h27, 8'h80, 8'h00);
        `CHK({b_oe, b_ind}, 2'h3)
        rd_reg(8'h26, 8'h80, 8'h80);
        wr_reg(8'h26, 8'h80);
        rd_reg(8'h26, 8'h80, 8'h00);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_add();
        wr_reg(8'h2A, 8'h10);
        add_run <= 0;
        cyc(190);
        rd_reg(8'h27, 8'h40, 8'h40);
        `CHK({b_oe, b_ind}, 2'h0)
        add_run <= 1;
        cyc(30);
        rd_reg(8'h27, 8'h40, 8'h00);
        wr_reg(8'h2A, 8'h00);
    endtask
    task automatic t_ext();
        rd_reg(8'h25, 8'h80, 8'h80);
        ext_run <= 1;
        cyc(30);
        rd_reg(8'h25, 8'h80, 8'h00);
        ext_run <= 0;
        cyc(50);
        rd_reg(8'h25, 8'h80, 8'h00);
        cyc(140);
        rd_reg(8'h25, 8'h80, 8'h80);
    endtask
    task automatic summarize();
        $display("bad_count=%0d compares=%0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        cyc(10);
        rstn <= 1;
        t_reset();
        t_h4();
        t_par();
        t_ais();
        t_loss();
        t_add();
        t_ext();
        summarize();
    end
    // Hang guard
    initial
    begin
        cyc(60000);
        bad_count++;
        summarize();
    end
endmodule // tb_top
`default_nettype wire
